/* bpd_ports.sv */
// Purpose: ports b, c and d with wishbone register access
// Assumes: classic wishbone slave, ack one cycle after request
// Notes:   peripheral modules drive override outputs and enables
//
// Notes on behaviour
// - output bit reads back the latch
// - input bit reads the pin level
// - writes reach the data latch only with byte lane 0 selected
// - write to input bit changes latch only
// - direction one drives pin, zero releases
// - reset clears every direction bit
// - reset leaves data latches untouched
// - each port eight latch and direction bits
// - spi enable takes port c bits 2-5
// - infrared enable takes port c bits 6-7
// - port c bit 0 always feeds second_external_interrupt
// - port c bit 0 pullup unless disabled
// - key enabled port d pins feed keyboard
// - two-wire enable takes port b bits 0-1
// - async serial enable takes port b bits 2-3
//
// Chosen here: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module bpd_ports (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [7:0]  port_b_pin_i,
  output logic      [7:0]  port_b_pin_o,
  output logic      [7:0]  port_b_pin_oe_n_o,
  input  wire logic [7:0]  port_c_pin_i,
  output logic      [7:0]  port_c_pin_o,
  output logic      [7:0]  port_c_pin_oe_n_o,
  input  wire logic [7:0]  port_d_pin_i,
  output logic      [7:0]  port_d_pin_o,
  output logic      [7:0]  port_d_pin_oe_n_o,
  input  wire logic        two_wire_sda_o_i,
  input  wire logic        two_wire_sda_oe_n_i,
  input  wire logic        two_wire_scl_o_i,
  input  wire logic        two_wire_scl_oe_n_i,
  output logic             two_wire_sda_o,
  output logic             two_wire_scl_o,
  input  wire logic        async_tx_i,
  output logic             async_rx_o,
  input  wire logic        spi_miso_i,
  input  wire logic        spi_miso_oe_n_i,
  input  wire logic        spi_mosi_i,
  input  wire logic        spi_mosi_oe_n_i,
  input  wire logic        spi_sck_i,
  input  wire logic        spi_sck_oe_n_i,
  output logic             spi_miso_o,
  output logic             spi_mosi_o,
  output logic             spi_ss_o,
  output logic             spi_sck_o,
  input  wire logic        infrared_transmit_pin_i,
  output logic             infrared_receive_pin_o,
  output logic             second_external_interrupt_o,
  output logic             pin0_pullup_en_o,
  output logic      [7:0]  key_interrupt_o,
  output logic      [7:0]  key_pullup_en_o,
  output logic      [4:0]  func_enable_o
);

  logic [4:0]  fe_q;
  logic [7:0]  key_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [5:0]  idx;
  logic        req;
  logic        wr_byte0;
  logic [7:0]  b_sel;
  logic [7:0]  b_out;
  logic [7:0]  b_oen;
  logic [7:0]  b_sync;
  logic [7:0]  b_rd;
  logic [7:0]  c_sel;
  logic [7:0]  c_out;
  logic [7:0]  c_oen;
  logic [7:0]  c_sync;
  logic [7:0]  c_rd;
  logic [7:0]  d_sync;
  logic [7:0]  d_rd;
  logic [7:0]  b_dir;
  logic [7:0]  c_dir;
  logic [7:0]  d_dir;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [5:0] a, input logic [5:0] target);
    hit = (a == target);
  endfunction

  assign idx      = wb_adr_i[7:2];
  assign req      = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_byte0 = req & wb_we_i & wb_sel_i[0];

  // ----------------------------------------------------------------
  // peripheral takeover
  // ----------------------------------------------------------------
  always_comb begin
    b_sel = 8'h00;
    b_out = 8'h00;
    b_oen = 8'hff;
    if (fe_q[bpd_pkg::FE_TWO_WIRE]) begin
      b_sel = b_sel | bpd_pkg::PB_PERIPH_MASK_TWO_WIRE;
      b_out[bpd_pkg::PB_TWO_WIRE_DATA] = two_wire_sda_o_i;
      b_oen[bpd_pkg::PB_TWO_WIRE_DATA] = two_wire_sda_oe_n_i;
      b_out[bpd_pkg::PB_TWO_WIRE_CLK]  = two_wire_scl_o_i;
      b_oen[bpd_pkg::PB_TWO_WIRE_CLK]  = two_wire_scl_oe_n_i;
    end
    if (fe_q[bpd_pkg::FE_ASYNC]) begin
      b_sel = b_sel | bpd_pkg::PB_PERIPH_MASK_ASYNC;
      b_out[bpd_pkg::PB_ASYNC_TX] = async_tx_i;
      b_oen[bpd_pkg::PB_ASYNC_TX] = 1'b0;
    end
  end

  always_comb begin
    c_sel = 8'h00;
    c_out = 8'h00;
    c_oen = 8'hff;
    if (fe_q[bpd_pkg::FE_SPI]) begin
      c_sel = c_sel | bpd_pkg::PC_PERIPH_MASK_SPI;
      c_out[bpd_pkg::PC_SPI_MISO] = spi_miso_i;
      c_oen[bpd_pkg::PC_SPI_MISO] = spi_miso_oe_n_i;
      c_out[bpd_pkg::PC_SPI_MOSI] = spi_mosi_i;
      c_oen[bpd_pkg::PC_SPI_MOSI] = spi_mosi_oe_n_i;
      c_out[bpd_pkg::PC_SPI_SCK]  = spi_sck_i;
      c_oen[bpd_pkg::PC_SPI_SCK]  = spi_sck_oe_n_i;
    end
    if (fe_q[bpd_pkg::FE_INFRARED]) begin
      c_sel = c_sel | bpd_pkg::PC_PERIPH_MASK_IR;
      c_out[bpd_pkg::PC_IR_TX] = infrared_transmit_pin_i;
      c_oen[bpd_pkg::PC_IR_TX] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // ports
  // ----------------------------------------------------------------
  bpd_port_bit8 u_port_b (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .wr_latch_i    (wr_byte0 & hit(idx, bpd_pkg::IDX_PORT_B_LATCH)),
    .wr_dir_i      (wr_byte0 & hit(idx, bpd_pkg::IDX_PORT_B_DIRECTION)),
    .wdata_i       (wb_dat_i[7:0]),
    .periph_sel_i  (b_sel),
    .periph_out_i  (b_out),
    .periph_oe_n_i (b_oen),
    .pin_i         (port_b_pin_i),
    .pin_o         (port_b_pin_o),
    .pin_oe_n_o    (port_b_pin_oe_n_o),
    .latch_o       (),
    .dir_o         (b_dir),
    .pin_sync_o    (b_sync),
    .rd_value_o    (b_rd)
  );

  bpd_port_bit8 u_port_c (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .wr_latch_i    (wr_byte0 & hit(idx, bpd_pkg::IDX_PORT_C_LATCH)),
    .wr_dir_i      (wr_byte0 & hit(idx, bpd_pkg::IDX_PORT_C_DIRECTION)),
    .wdata_i       (wb_dat_i[7:0]),
    .periph_sel_i  (c_sel),
    .periph_out_i  (c_out),
    .periph_oe_n_i (c_oen),
    .pin_i         (port_c_pin_i),
    .pin_o         (port_c_pin_o),
    .pin_oe_n_o    (port_c_pin_oe_n_o),
    .latch_o       (),
    .dir_o         (c_dir),
    .pin_sync_o    (c_sync),
    .rd_value_o    (c_rd)
  );

  bpd_port_bit8 u_port_d (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .wr_latch_i    (wr_byte0 & hit(idx, bpd_pkg::IDX_PORT_D_LATCH)),
    .wr_dir_i      (wr_byte0 & hit(idx, bpd_pkg::IDX_PORT_D_DIRECTION)),
    .wdata_i       (wb_dat_i[7:0]),
    .periph_sel_i  (8'h00),
    .periph_out_i  (8'h00),
    .periph_oe_n_i (8'hff),
    .pin_i         (port_d_pin_i),
    .pin_o         (port_d_pin_o),
    .pin_oe_n_o    (port_d_pin_oe_n_o),
    .latch_o       (),
    .dir_o         (d_dir),
    .pin_sync_o    (d_sync),
    .rd_value_o    (d_rd)
  );

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fe_q <= bpd_pkg::FE_RESET;
    end else if (wr_byte0 & hit(idx, bpd_pkg::IDX_FUNC_ENABLE)) begin
      fe_q <= wb_dat_i[4:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_q <= bpd_pkg::KEY_RESET;
    end else if (wr_byte0 & hit(idx, bpd_pkg::IDX_KEY_ENABLE)) begin
      key_q <= wb_dat_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // peripheral inputs from synchronised pins, pullup and enable outputs from registers
  // ----------------------------------------------------------------
  assign second_external_interrupt_o = c_sync[bpd_pkg::PC_SECOND_EXTERNAL_INTERRUPT];
  assign pin0_pullup_en_o = ~fe_q[bpd_pkg::FE_PULLUP_DIS];
  assign key_interrupt_o  = ~key_q | d_sync;
  assign key_pullup_en_o  = key_q;
  assign func_enable_o    = fe_q;
  assign two_wire_sda_o   = b_sync[bpd_pkg::PB_TWO_WIRE_DATA];
  assign two_wire_scl_o   = b_sync[bpd_pkg::PB_TWO_WIRE_CLK];
  assign async_rx_o       = b_sync[bpd_pkg::PB_ASYNC_RX] | ~fe_q[bpd_pkg::FE_ASYNC];
  assign spi_miso_o       = c_sync[bpd_pkg::PC_SPI_MISO];
  assign spi_mosi_o       = c_sync[bpd_pkg::PC_SPI_MOSI];
  assign spi_ss_o         = c_sync[bpd_pkg::PC_SPI_SS];
  assign spi_sck_o        = c_sync[bpd_pkg::PC_SPI_SCK];
  assign infrared_receive_pin_o = c_sync[bpd_pkg::PC_IR_RX];

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (req) begin
      unique case (idx)
        bpd_pkg::IDX_PORT_B_LATCH:     rdata_q <= {24'h00_0000, b_rd};
        bpd_pkg::IDX_PORT_C_LATCH:     rdata_q <= {24'h00_0000, c_rd};
        bpd_pkg::IDX_PORT_D_LATCH:     rdata_q <= {24'h00_0000, d_rd};
        bpd_pkg::IDX_PORT_B_DIRECTION: rdata_q <= {24'h00_0000, b_dir};
        bpd_pkg::IDX_PORT_C_DIRECTION: rdata_q <= {24'h00_0000, c_dir};
        bpd_pkg::IDX_PORT_D_DIRECTION: rdata_q <= {24'h00_0000, d_dir};
        bpd_pkg::IDX_FUNC_ENABLE:      rdata_q <= {27'h0, fe_q};
        bpd_pkg::IDX_KEY_ENABLE:       rdata_q <= {24'h00_0000, key_q};
        default:                       rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

endmodule
`default_nettype wire

/* bpd_pkg.sv */
// Purpose: constants for the bidirectional port block (ports b, c, d)
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes:   port data at printed offsets times four; other registers chosen here
package bpd_pkg;

  localparam int unsigned PORT_W = 8;
  localparam int unsigned ADDR_W = 8;

  // register indices
  localparam logic [5:0] IDX_PORT_B_LATCH     = 6'h01;
  localparam logic [5:0] IDX_PORT_C_LATCH     = 6'h02;
  localparam logic [5:0] IDX_PORT_D_LATCH     = 6'h03;
  localparam logic [5:0] IDX_PORT_B_DIRECTION = 6'h05;
  localparam logic [5:0] IDX_PORT_C_DIRECTION = 6'h06;
  localparam logic [5:0] IDX_PORT_D_DIRECTION = 6'h07;
  localparam logic [5:0] IDX_FUNC_ENABLE      = 6'h08;
  localparam logic [5:0] IDX_KEY_ENABLE       = 6'h09;

  // function enable register fields
  localparam int unsigned FE_TWO_WIRE  = 0;
  localparam int unsigned FE_ASYNC     = 1;
  localparam int unsigned FE_SPI       = 2;
  localparam int unsigned FE_INFRARED  = 3;
  localparam int unsigned FE_PULLUP_DIS = 4;
  localparam int unsigned FE_W         = 5;

  // pin positions
  localparam int unsigned PB_TWO_WIRE_DATA = 0;
  localparam int unsigned PB_TWO_WIRE_CLK  = 1;
  localparam int unsigned PB_ASYNC_TX      = 2;
  localparam int unsigned PB_ASYNC_RX      = 3;
  localparam int unsigned PC_SECOND_EXTERNAL_INTERRUPT          = 0;
  localparam int unsigned PC_SPI_MISO      = 2;
  localparam int unsigned PC_SPI_MOSI      = 3;
  localparam int unsigned PC_SPI_SS        = 4;
  localparam int unsigned PC_SPI_SCK       = 5;
  localparam int unsigned PC_IR_TX         = 6;
  localparam int unsigned PC_IR_RX         = 7;

  localparam logic [7:0] DIR_RESET  = 8'h00;
  localparam logic [7:0] KEY_RESET  = 8'h00;
  localparam logic [4:0] FE_RESET   = 5'h00;
  localparam logic [7:0] PB_PERIPH_MASK_TWO_WIRE = 8'h03;
  localparam logic [7:0] PB_PERIPH_MASK_ASYNC    = 8'h0c;
  localparam logic [7:0] PC_PERIPH_MASK_SPI      = 8'h3c;
  localparam logic [7:0] PC_PERIPH_MASK_IR       = 8'hc0;

endpackage

/* bpd_port_bit8.sv */
// Purpose: one 8-bit port: latch, direction, peripheral override, synchroniser
// Assumes: single clock, synchronous reset
// Notes:   latch holds its value through reset
`timescale 1ns/100ps
`default_nettype none
module bpd_port_bit8 (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       wr_latch_i,
  input  wire logic       wr_dir_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [7:0] periph_sel_i,
  input  wire logic [7:0] periph_out_i,
  input  wire logic [7:0] periph_oe_n_i,
  input  wire logic [7:0] pin_i,
  output logic      [7:0] pin_o,
  output logic      [7:0] pin_oe_n_o,
  output logic      [7:0] latch_o,
  output logic      [7:0] dir_o,
  output logic      [7:0] pin_sync_o,
  output logic      [7:0] rd_value_o
);

  logic [7:0] latch_q;
  logic [7:0] dir_q;
  logic [7:0] meta_q;
  logic [7:0] sync_q;

  // ----------------------------------------------------------------
  // data latch
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (wr_latch_i) begin
      latch_q <= wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // direction
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_q <= bpd_pkg::DIR_RESET;
    end else if (wr_dir_i) begin
      dir_q <= wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    meta_q <= pin_i;
    sync_q <= meta_q;
  end

  // ----------------------------------------------------------------
  // pad drive and read mux
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (periph_sel_i[i]) begin
        pin_o[i]      = periph_out_i[i];
        pin_oe_n_o[i] = periph_oe_n_i[i];
      end else begin
        pin_o[i]      = latch_q[i];
        pin_oe_n_o[i] = ~dir_q[i];
      end
    end
  end

  assign rd_value_o = (dir_q & latch_q) | (~dir_q & sync_q);
  assign latch_o    = latch_q;
  assign dir_o      = dir_q;
  assign pin_sync_o = sync_q;

endmodule
`default_nettype wire

/* bpd_ports_monitor.sv */
// Purpose: concurrent checks on the port block pins and bus
// Assumes: one clock, sync active-high reset
// Notes:   bound to every bpd_ports instance
`timescale 1ns/100ps
`default_nettype none
module bpd_ports_monitor (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic [7:0] port_b_pin_o,
  input wire logic [7:0] port_b_pin_oe_n_o,
  input wire logic [7:0] port_c_pin_i,
  input wire logic [7:0] port_c_pin_o,
  input wire logic [7:0] port_c_pin_oe_n_o,
  input wire logic [7:0] port_d_pin_oe_n_o,
  input wire logic       two_wire_sda_o_i,
  input wire logic       two_wire_sda_oe_n_i,
  input wire logic       async_tx_i,
  input wire logic       spi_mosi_i,
  input wire logic       spi_mosi_oe_n_i,
  input wire logic       infrared_transmit_pin_i,
  input wire logic       second_external_interrupt_o,
  input wire logic       pin0_pullup_en_o,
  input wire logic [4:0] func_enable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  dir_clear_a: assert property ($fell(rst_i) |->
    (&port_b_pin_oe_n_o) && (&port_c_pin_oe_n_o) && (&port_d_pin_oe_n_o))
    else $error("pin driven after reset");
  second_external_interrupt_sync_a: assert property (!$past(rst_i) && !$past(rst_i, 2) |->
    second_external_interrupt_o == $past(port_c_pin_i[0], 2))
    else $error("second interrupt not two-stage pin level");
  pullup_ctl_a: assert property (pin0_pullup_en_o == !func_enable_o[4])
    else $error("pullup enable wrong");
  spi_take_a: assert property (func_enable_o[2] |->
    port_c_pin_o[3] == spi_mosi_i &&
    port_c_pin_oe_n_o[3] == spi_mosi_oe_n_i && port_c_pin_oe_n_o[4])
    else $error("spi pins not taken over");
  ir_take_a: assert property (func_enable_o[3] |->
    port_c_pin_o[6] == infrared_transmit_pin_i && !port_c_pin_oe_n_o[6])
    else $error("infrared transmit not taken over");
  twi_take_a: assert property (func_enable_o[0] |->
    port_b_pin_o[0] == two_wire_sda_o_i &&
    port_b_pin_oe_n_o[0] == two_wire_sda_oe_n_i)
    else $error("two-wire data not taken over");
  async_take_a: assert property (func_enable_o[1] |->
    port_b_pin_o[2] == async_tx_i && !port_b_pin_oe_n_o[2])
    else $error("async transmit not taken over");
  cover property (wb_ack_o);
  cover property (func_enable_o[2] && func_enable_o[3]);
  cover property ($fell(rst_i));
endmodule
bind bpd_ports bpd_ports_monitor bpd_ports_monitor_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .port_b_pin_o, .port_b_pin_oe_n_o, .port_c_pin_i, .port_c_pin_o,
  .port_c_pin_oe_n_o, .port_d_pin_oe_n_o, .two_wire_sda_o_i, .two_wire_sda_oe_n_i,
  .async_tx_i, .spi_mosi_i, .spi_mosi_oe_n_i, .infrared_transmit_pin_i,
  .second_external_interrupt_o, .pin0_pullup_en_o, .func_enable_o);
`default_nettype wire

/* bpd_pins_model.sv */
// Purpose: pad model of one 8-bit port
// Assumes: external source drives every released pin
// Notes:   released pins follow the outside level only
`timescale 1ns/100ps
`default_nettype none
module bpd_pins_model (
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] oe_n_i,
  input  wire logic [7:0] ext_i,
  output logic      [7:0] pad_o
);
  // driven bits take the port value, released bits the outside level
  assign pad_o = (drv_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule
`default_nettype wire

/* bpd_ports_tb_top.sv */
// Purpose: self-checking bench for the port block
// Assumes: wishbone ack one cycle after request
// Notes:   read expectations queued, checked at ack
`timescale 1ns/100ps
`default_nettype none
module bpd_ports_tb_top;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, second_external_interrupt, pue;
  logic [7:0]  adr = 0, m, l, l2, e, k, la, kio, kpe, q[$];
  logic [7:0]  ext[3] = '{0, 0, 0}, ls[3], oe[3], po[3], pad[3];
  logic [11:0] per = 0;
  logic [31:0] dat = 0, rdat, s = 75;
  logic [4:0]  fe;
  logic        ack;
  logic [3:0]  sel = 4'h1;
  logic [3:0]  wsel = 4'h1;
  wire logic [7:0] rxo;
  int          n_fail = 0, n_compared = 0;
  always #2.5 clk_i = ~clk_i;
  for (genvar g = 0; g < 3; g++) begin : pm
    bpd_pins_model bpd_pins_model_i (.drv_i(po[g]), .oe_n_i(oe[g]), .ext_i(ext[g]),
      .pad_o(pad[g]));
  end
  bpd_ports bpd_ports_i (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .port_b_pin_i(pad[0]), .port_b_pin_o(po[0]), .port_b_pin_oe_n_o(oe[0]),
    .port_c_pin_i(pad[1]), .port_c_pin_o(po[1]), .port_c_pin_oe_n_o(oe[1]),
    .port_d_pin_i(pad[2]), .port_d_pin_o(po[2]), .port_d_pin_oe_n_o(oe[2]),
    .two_wire_sda_o_i(per[0]), .two_wire_sda_oe_n_i(per[1]), .two_wire_scl_o_i(per[2]),
    .two_wire_scl_oe_n_i(per[3]), .two_wire_sda_o(rxo[0]), .two_wire_scl_o(rxo[1]),
    .async_tx_i(per[4]), .async_rx_o(rxo[2]), .spi_miso_i(per[5]), .spi_miso_oe_n_i(per[6]),
    .spi_mosi_i(per[7]), .spi_mosi_oe_n_i(per[8]), .spi_sck_i(per[9]),
    .spi_sck_oe_n_i(per[10]), .spi_miso_o(rxo[3]), .spi_mosi_o(rxo[4]), .spi_ss_o(rxo[5]),
    .spi_sck_o(rxo[6]), .infrared_transmit_pin_i(per[11]), .infrared_receive_pin_o(rxo[7]),
    .second_external_interrupt_o(second_external_interrupt), .pin0_pullup_en_o(pue),
    .key_interrupt_o(kio), .key_pullup_en_o(kpe), .func_enable_o(fe));
  function automatic logic [7:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[7:0];
  endfunction
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // read: d is the expected byte
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we  <= w;
    adr <= a;
    dat <= {24'h0, d};
    sel <= wsel;
    if (!w) q.push_back(d);
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (ack === 1'b1 && !we) begin
      chk("rdata", rdat[7:0], q.pop_front());
      chk("rdata_hi", rdat[31:24], 8'h00);
    end
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    for (int p = 0; p < 3; p++) wb(0, 8'(8'h14 + 4 * p), 8'h00);
    wb(0, 8'h20, 8'h00);
    wb(1, 8'h3c, 8'hff);
    wb(0, 8'h3c, 8'h00);
    for (int i = 0; i < 12; i++) begin
      la = 8'(4 + 4 * (i % 3));
      m = rnd();
      l = rnd();
      e = rnd();
      l2 = rnd();
      ext[i % 3] <= e;
      wb(1, la, l);
      wb(1, la + 8'h10, m);
      repeat (3) @(posedge clk_i);
      chk("oe_n", oe[i % 3], ~m);
      chk("drive", po[i % 3] & m, l & m);
      wb(0, la, (l & m) | (e & ~m));
      wb(1, la, l2);
      wb(0, la, (l2 & m) | (e & ~m));
      wb(1, la + 8'h10, 8'hff);
      wb(0, la, l2);
      ls[i % 3] = l2;
    end
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    for (int p = 0; p < 3; p++) begin
      wb(0, 8'(8'h14 + 4 * p), 8'h00);
      wb(1, 8'(8'h14 + 4 * p), 8'hff);
      wb(0, 8'(4 + 4 * p), ls[p]);
    end
    // low lane not selected: write must be dropped
    wsel = 4'h0;
    wb(1, 8'h04, ~ls[0]);
    wsel = 4'h1;
    wb(0, 8'h04, ls[0]);
    repeat (3) @(posedge clk_i);
    chk("second_external_interrupt", {7'h0, second_external_interrupt}, {7'h0, ls[1][0]});
    k = rnd();
    e = rnd();
    ext[2] <= e;
    wb(1, 8'h1c, 8'h00);
    wb(1, 8'h24, k);
    repeat (4) @(posedge clk_i);
    chk("key_irq", kio, e | ~k);
    chk("key_pullup", kpe, k);
    chk("pullup", {7'h0, pue}, 8'h01);
    chk("rx_idle", {7'h0, rxo[2]}, 8'h01);
    wb(1, 8'h20, 8'h10);
    chk("pullup", {7'h0, pue}, 8'h00);
    wb(1, 8'h20, 8'h0f);
    repeat (6) begin
      per <= {4'(rnd()), rnd()};
      @(posedge clk_i);
    end
    // let the pad levels pass both synchroniser stages
    repeat (3) @(posedge clk_i);
    chk("func_en", {3'h0, fe}, 8'h0f);
    chk("ss_oe_n", {7'h0, oe[1][4]}, 8'h01);
    chk("ir_tx", {7'h0, po[1][6]}, {7'h0, per[11]});
    la = {pad[1][7], pad[1][5], pad[1][4], pad[1][3], pad[1][2], pad[0][3], pad[0][1], pad[0][0]};
    chk("rx_pins", rxo, la);
    finish_test();
  end
endmodule
`default_nettype wire
